// File: core/coeff_byte_reg.sv
// one byte-wide coefficient register with its own reset value
`timescale 1ns/1ps
module coeff_byte_reg
  import coeff_regs_pkg::*;
#(
  parameter logic [7:0] reset_value = 8'h00
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // write strobe and data
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // stored byte
  output logic [7:0]      value
);

  typedef struct packed {
    logic [7:0] value;
  } byte_state_t;

  byte_state_t state;
  byte_state_t next_state;

  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.value = wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '{value: reset_value};
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;

endmodule

// File: core/filter_coefficient_regs.sv
// filter coefficient register bank behind an axi4-lite slave
//
// Functional notes
// [RULE1] coefficients are 16-bit signed, both bytes read/write
// [RULE2] high byte is bits 15:8, low byte 7:0
// [RULE3] rch numerator-zero low byte resets to 0x55
// [RULE4] rch numerator-zero high byte resets to 0x39
// [RULE5] rch numerator-one resets to 0xF3 / 0x2D
// [RULE6] rch denominator-one resets to 0x53 / 0x7E
// [RULE7] spatial attenuation resets to 0x7F / 0xFF
// [RULE8] reserved indices 55-64 read zero, ignore writes
// [RULE9] lch highpass numerator-zero resets to 0x39 / 0x55
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module filter_coefficient_regs
  import coeff_regs_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // write address channel
  input  wire logic [addr_width-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // write data channel
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // write response channel
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // read address channel
  input  wire logic [addr_width-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // read data channel
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // coefficients to the filter datapath
  output coeff_bus_t                 coeffs
);

  // ----------------------------------------------------------------
  // register slots
  // ----------------------------------------------------------------
  localparam int n_regs = 10;

  localparam logic [6:0] slot_idx [n_regs] = '{
    idx_rch_num_zero_high, idx_rch_num_zero_low, idx_rch_num_one_high, idx_rch_num_one_low,
    idx_rch_den_one_high,  idx_rch_den_one_low,  idx_spat_high,        idx_spat_low,
    idx_lhp_num_zero_high, idx_lhp_num_zero_low
  };

  localparam logic [7:0] slot_rst [n_regs] = '{
    rst_rch_num_zero_high, rst_rch_num_zero_low, rst_rch_num_one_high, rst_rch_num_one_low,
    rst_rch_den_one_high,  rst_rch_den_one_low,  rst_spat_high,        rst_spat_low,
    rst_lhp_num_zero_high, rst_lhp_num_zero_low
  };

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  aw_held;
    logic [addr_width-1:0] aw_addr;
    logic                  w_held;
    logic [7:0]            w_byte;
    logic                  w_lane0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  awready;
    logic                  wready;
    logic                  arready;
    coeff_bus_t            coeffs;
  } bus_state_t;

  bus_state_t state;
  bus_state_t next_state;

  logic [7:0]  reg_value [n_regs];
  logic [n_regs-1:0] reg_hit_w;
  logic [n_regs-1:0] reg_wr;
  logic [6:0]  w_index;
  logic [6:0]  r_index;
  logic        w_fire;
  logic        w_rsvd;
  logic        r_rsvd;
  logic        r_hit;
  logic [7:0]  r_byte;

  assign w_index = state.aw_addr[addr_lsb +: 7];
  assign r_index = s_axi_araddr[addr_lsb +: 7];
  // write commits once both halves are held and no response is pending
  assign w_fire  = state.aw_held && state.w_held && !state.bvalid;
  assign w_rsvd  = (w_index >= idx_rsvd_first) && (w_index <= idx_rsvd_last);
  assign r_rsvd  = (r_index >= idx_rsvd_first) && (r_index <= idx_rsvd_last);

  // ----------------------------------------------------------------
  // byte registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < n_regs; gi++) begin : g_reg
      assign reg_hit_w[gi] = (w_index == slot_idx[gi]);
      // only lane 0 carries the byte; other lanes leave it alone
      assign reg_wr[gi]    = w_fire && reg_hit_w[gi] && state.w_lane0; // RULE1
      coeff_byte_reg #(
        .reset_value (slot_rst[gi]) // RULE3 RULE4 RULE5 RULE6 RULE7 RULE9
      ) coeff_byte_reg_i (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (reg_wr[gi]),
        .wr_data (state.w_byte),
        .value   (reg_value[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    r_byte = rsvd_value;
    r_hit  = r_rsvd; // RULE8
    for (int i = 0; i < n_regs; i++) begin
      if (r_index == slot_idx[i]) begin
        r_byte = reg_value[i];
        r_hit  = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (s_axi_awvalid && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_held) begin
      next_state.w_held  = 1'b1;
      next_state.w_byte  = s_axi_wdata[7:0];
      next_state.w_lane0 = s_axi_wstrb[0];
    end
    if (w_fire) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      // reserved slots accept the beat but keep zero
      if (w_rsvd || (|reg_hit_w)) begin // RULE8
        next_state.bresp = resp_okay;
      end else begin
        next_state.bresp = resp_slverr;
      end
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = {24'h000000, r_byte};
      next_state.rresp  = r_hit ? resp_okay : resp_slverr;
    end
    // ready flags kept in flops so no gate sits between state and pin
    next_state.awready = !next_state.aw_held;
    next_state.wready  = !next_state.w_held;
    next_state.arready = !next_state.rvalid;
    // high byte above low byte, read as signed
    next_state.coeffs.rch_numerator_zero_coeff    = {reg_value[0], reg_value[1]}; // RULE2
    next_state.coeffs.rch_numerator_one_coeff     = {reg_value[2], reg_value[3]}; // RULE2
    next_state.coeffs.rch_denominator_one_coeff   = {reg_value[4], reg_value[5]}; // RULE2
    next_state.coeffs.spatial_atten_coeff         = {reg_value[6], reg_value[7]}; // RULE2
    next_state.coeffs.lch_hp_numerator_zero_coeff = {reg_value[8], reg_value[9]}; // RULE2
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '{
        aw_held: 1'b0, aw_addr: '0, w_held: 1'b0, w_byte: 8'h00, w_lane0: 1'b0,
        bvalid: 1'b0, bresp: resp_okay, rvalid: 1'b0, rdata: 32'h00000000,
        rresp: resp_okay,
        awready: 1'b1, wready: 1'b1, arready: 1'b1,
        coeffs: '{rch_numerator_zero_coeff:    {rst_rch_num_zero_high, rst_rch_num_zero_low},
                  rch_numerator_one_coeff:     {rst_rch_num_one_high, rst_rch_num_one_low},
                  rch_denominator_one_coeff:   {rst_rch_den_one_high, rst_rch_den_one_low},
                  spatial_atten_coeff:         {rst_spat_high, rst_spat_low},
                  lch_hp_numerator_zero_coeff: {rst_lhp_num_zero_high, rst_lhp_num_zero_low}}
      };
    end else begin
      state <= next_state;
    end
  end

  // every port leaves a flop directly
  assign s_axi_awready = state.awready;
  assign s_axi_wready  = state.wready;
  assign s_axi_arready = state.arready;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign coeffs        = state.coeffs;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_coeff_follows_bytes;
    @(posedge aclk) disable iff (!aresetn)
      coeffs.rch_numerator_one_coeff == {$past(reg_value[2]), $past(reg_value[3])};
  endproperty
  a_coeff_follows_bytes: assert property (p_coeff_follows_bytes) // RULE2
    else $error("numerator-one coefficient not assembled high over low");

  property p_num_zero_low_reset;
    @(posedge aclk) $rose(aresetn) |-> reg_value[1] == rst_rch_num_zero_low;
  endproperty
  a_num_zero_low_reset: assert property (p_num_zero_low_reset) // RULE3
    else $error("numerator-zero low byte wrong after reset");

  property p_num_zero_high_reset;
    @(posedge aclk) $rose(aresetn) |-> reg_value[0] == rst_rch_num_zero_high;
  endproperty
  a_num_zero_high_reset: assert property (p_num_zero_high_reset) // RULE4
    else $error("numerator-zero high byte wrong after reset");

  property p_num_one_reset;
    @(posedge aclk) $rose(aresetn) |->
      {reg_value[2], reg_value[3]} == {rst_rch_num_one_high, rst_rch_num_one_low};
  endproperty
  a_num_one_reset: assert property (p_num_one_reset) // RULE5
    else $error("numerator-one wrong after reset");

  property p_den_one_reset;
    @(posedge aclk) $rose(aresetn) |->
      {reg_value[4], reg_value[5]} == {rst_rch_den_one_high, rst_rch_den_one_low};
  endproperty
  a_den_one_reset: assert property (p_den_one_reset) // RULE6
    else $error("denominator-one wrong after reset");

  property p_spat_reset;
    @(posedge aclk) $rose(aresetn) |=>
      coeffs.spatial_atten_coeff == {rst_spat_high, rst_spat_low};
  endproperty
  a_spat_reset: assert property (p_spat_reset) // RULE7
    else $error("spatial attenuation wrong after reset");

  property p_rsvd_reads_zero;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && r_rsvd) |=> (s_axi_rvalid && s_axi_rdata == 32'h0);
  endproperty
  a_rsvd_reads_zero: assert property (p_rsvd_reads_zero) // RULE8
    else $error("reserved register read not zero");

  property p_lhp_reset;
    @(posedge aclk) $rose(aresetn) |->
      {reg_value[8], reg_value[9]} == {rst_lhp_num_zero_high, rst_lhp_num_zero_low};
  endproperty
  a_lhp_reset: assert property (p_lhp_reset) // RULE9
    else $error("left highpass numerator-zero wrong after reset");

  property p_write_lands;
    @(posedge aclk) disable iff (!aresetn)
      (w_fire && state.w_lane0 && w_index == idx_spat_low) |=>
        reg_value[7] == $past(state.w_byte);
  endproperty
  a_write_lands: assert property (p_write_lands) // RULE1
    else $error("write to spatial low byte not stored");

  property p_num_zero_follows_bytes;
    @(posedge aclk) disable iff (!aresetn)
      coeffs.rch_numerator_zero_coeff == {$past(reg_value[0]), $past(reg_value[1])};
  endproperty
  a_num_zero_follows_bytes: assert property (p_num_zero_follows_bytes) // RULE2
    else $error("numerator-zero coefficient not assembled high over low");

  property p_lhp_follows_bytes;
    @(posedge aclk) disable iff (!aresetn)
      coeffs.lch_hp_numerator_zero_coeff == {$past(reg_value[8]), $past(reg_value[9])};
  endproperty
  a_lhp_follows_bytes: assert property (p_lhp_follows_bytes) // RULE2
    else $error("left highpass coefficient not assembled high over low");

  // a write with lane 0 off must not touch the byte
  property p_lane_off_keeps_byte;
    @(posedge aclk) disable iff (!aresetn)
      (w_fire && !state.w_lane0 && w_index == idx_rch_num_zero_high) |=>
        reg_value[0] == $past(reg_value[0]);
  endproperty
  a_lane_off_keeps_byte: assert property (p_lane_off_keeps_byte) // RULE1
    else $error("write with lane 0 off changed a byte");

  property p_unmapped_write_refused;
    @(posedge aclk) disable iff (!aresetn)
      (w_fire && !w_rsvd && !(|reg_hit_w)) |=>
        (s_axi_bvalid && s_axi_bresp == resp_slverr) ##1 $stable(coeffs);
  endproperty
  a_unmapped_write_refused: assert property (p_unmapped_write_refused)
    else $error("unmapped write not refused or changed a coefficient");

  property p_ready_after_reset;
    @(posedge aclk) $rose(aresetn) |->
      (s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid);
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset)
    else $error("bus channels not idle after reset");

  property p_aw_taken_blocks;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready;
  endproperty
  a_aw_taken_blocks: assert property (p_aw_taken_blocks)
    else $error("write address channel still ready while holding an address");

  property p_w_taken_blocks;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_wvalid && s_axi_wready) |=> !s_axi_wready;
  endproperty
  a_w_taken_blocks: assert property (p_w_taken_blocks)
    else $error("write data channel still ready while holding data");

  property p_read_returns_byte;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && r_index == idx_rch_num_one_high) |=>
        (s_axi_rvalid && s_axi_rdata == {24'h000000, $past(reg_value[2])});
  endproperty
  a_read_returns_byte: assert property (p_read_returns_byte) // RULE1
    else $error("numerator-one high byte read back wrong");

  property p_rvalid_needs_request;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s_axi_rvalid) |-> $past(s_axi_arvalid);
  endproperty
  a_rvalid_needs_request: assert property (p_rvalid_needs_request)
    else $error("read data raised without a read request");

endmodule

// File: inc/coeff_regs_pkg.sv
// shared constants and carrier types for the filter coefficient bank
package coeff_regs_pkg;

  // register indices; byte address is four times the index
  localparam logic [6:0] idx_rch_num_zero_high = 7'h2F;
  localparam logic [6:0] idx_rch_num_zero_low  = 7'h30;
  localparam logic [6:0] idx_rch_num_one_high  = 7'h31;
  localparam logic [6:0] idx_rch_num_one_low   = 7'h32;
  localparam logic [6:0] idx_rch_den_one_high  = 7'h33;
  localparam logic [6:0] idx_rch_den_one_low   = 7'h34;
  localparam logic [6:0] idx_spat_high         = 7'h35;
  localparam logic [6:0] idx_spat_low          = 7'h36;
  localparam logic [6:0] idx_rsvd_first        = 7'h37;
  localparam logic [6:0] idx_rsvd_last         = 7'h40;
  localparam logic [6:0] idx_lhp_num_zero_high = 7'h41;
  localparam logic [6:0] idx_lhp_num_zero_low  = 7'h42;

  // word index lives in address bits 8:2
  localparam int addr_lsb   = 2;
  localparam int addr_width = 9;

  // reset values
  localparam logic [7:0] rst_rch_num_zero_high = 8'h39;
  localparam logic [7:0] rst_rch_num_zero_low  = 8'h55;
  localparam logic [7:0] rst_rch_num_one_high  = 8'hF3;
  localparam logic [7:0] rst_rch_num_one_low   = 8'h2D;
  localparam logic [7:0] rst_rch_den_one_high  = 8'h53;
  localparam logic [7:0] rst_rch_den_one_low   = 8'h7E;
  localparam logic [7:0] rst_spat_high         = 8'h7F;
  localparam logic [7:0] rst_spat_low          = 8'hFF;
  localparam logic [7:0] rst_lhp_num_zero_high = 8'h39;
  localparam logic [7:0] rst_lhp_num_zero_low  = 8'h55;
  localparam logic [7:0] rsvd_value            = 8'h00;

  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // one coefficient as two byte registers
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } coeff_pair_t;

  // coefficients presented to the filter datapath
  typedef struct packed {
    logic signed [15:0] rch_numerator_zero_coeff;
    logic signed [15:0] rch_numerator_one_coeff;
    logic signed [15:0] rch_denominator_one_coeff;
    logic signed [15:0] spatial_atten_coeff;
    logic signed [15:0] lch_hp_numerator_zero_coeff;
  } coeff_bus_t;

endpackage

// File: sim/filter_coefficient_regs_bench.sv
// self-checking bench for the filter coefficient register bank
`timescale 1ns/1ps
module filter_coefficient_regs_bench
  import coeff_regs_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [addr_width-1:0] awaddr = '0;
  logic                  awvalid = 1'b0;
  logic                  awready;
  logic [31:0]           wdata = '0;
  logic [3:0]            wstrb = '0;
  logic                  wvalid = 1'b0;
  logic                  wready;
  logic [1:0]            bresp;
  logic                  bvalid;
  logic                  bready = 1'b0;
  logic [addr_width-1:0] araddr = '0;
  logic                  arvalid = 1'b0;
  logic                  arready;
  logic [31:0]           rdata;
  logic [1:0]            rresp;
  logic                  rvalid;
  logic                  rready = 1'b0;
  coeff_bus_t            coeffs;
  int                    n_mismatch = 0;
  int                    compares = 0;
  logic [6:0]            idx_tab [10];
  logic [7:0]            rst_tab [10];
  logic [7:0]            wr_tab  [10];

  always #2 aclk = ~aclk;

  filter_coefficient_regs filter_coefficient_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .coeffs(coeffs)
  );

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  // bready raised with the request; the slave may answer only after both
  task automatic axi_write(input logic [6:0] idx, input logic [7:0] d,
                           input logic [3:0] strb, input logic [1:0] er);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'hFFFFFF, d};
    wstrb <= strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic axi_read(input logic [6:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        check("rdata", rdata, {24'h0, ed});
        check("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) begin
      n_mismatch++;
      summarize();
    end
  endtask

  // pairs sit high then low, coeff k in bits 16*(4-k) of the bus
  task automatic check_coeffs(input logic [7:0] tab [10]);
    repeat (2) @(posedge aclk);
    for (int k = 0; k < 5; k++) begin
      check("coeff", {16'h0, coeffs[16*(4-k) +: 16]}, {16'h0, tab[2*k], tab[2*k+1]});
    end
  endtask

  task automatic check_resets();
    for (int i = 0; i < 10; i++) begin
      axi_read(idx_tab[i], rst_tab[i], resp_okay);
    end
    check_coeffs(rst_tab);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    idx_tab = '{idx_rch_num_zero_high, idx_rch_num_zero_low, idx_rch_num_one_high,
                idx_rch_num_one_low, idx_rch_den_one_high, idx_rch_den_one_low,
                idx_spat_high, idx_spat_low, idx_lhp_num_zero_high, idx_lhp_num_zero_low};
    rst_tab = '{8'h39, 8'h55, 8'hF3, 8'h2D, 8'h53, 8'h7E, 8'h7F, 8'hFF, 8'h39, 8'h55};
    // extremes of the signed range plus mixed patterns
    wr_tab = '{8'h80, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'hA5, 8'h5A};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check_resets();
    $display("test reset_values done");
    for (int i = 0; i < 10; i++) begin
      axi_write(idx_tab[i], wr_tab[i], 4'hF, resp_okay);
    end
    for (int i = 0; i < 10; i++) begin
      axi_read(idx_tab[i], wr_tab[i], resp_okay);
    end
    check_coeffs(wr_tab);
    $display("test write_readback done");
    // lane 0 disabled must leave the byte alone
    axi_write(idx_rch_num_zero_high, 8'h11, 4'hE, resp_okay);
    axi_read(idx_rch_num_zero_high, 8'h80, resp_okay);
    $display("test strobe done");
    // reserved range is read only; never written from here
    axi_read(idx_rsvd_first, rsvd_value, resp_okay);
    axi_read(7'h3B, rsvd_value, resp_okay);
    axi_read(idx_rsvd_last, rsvd_value, resp_okay);
    $display("test reserved done");
    axi_read(7'h10, 8'h00, resp_slverr);
    axi_read(7'h43, 8'h00, resp_slverr);
    axi_write(7'h10, 8'h22, 4'hF, resp_slverr);
    axi_read(idx_lhp_num_zero_low, 8'h5A, resp_okay);
    $display("test unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check_resets();
    $display("test second_reset done");
    summarize();
  end
endmodule
